//--- src/serial_port_pkg.sv
/*
  Shared constants for the serial port: clock rate, line rate table, register
  offsets, field positions, reset values and setting encodings.
  Assumes a single 200 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
`default_nettype none

package serial_port_pkg;

  // ************************************************************
  // Clock and line rates
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned CLOCK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int NUM_RATES = 17;
  localparam int unsigned RATE_TABLE [NUM_RATES] = '{250000, 128000, 115200, 57600, 38400, 31250, 28800,
    19200, 14400, 9600, 4800, 2400, 1200, 600, 300, 150, 110};
  localparam int DIV_W = 21;
  localparam logic [4:0] RATE_RESET_IDX = 5'h02;
  localparam logic [4:0] RATE_LAST_IDX = 5'h10;

  // ************************************************************
  // Register map (byte addresses) and fields
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] CFG_OFFSET = 8'h00;
  localparam logic [7:0] TXDATA_OFFSET = 8'h04;
  localparam logic [7:0] RXDATA_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;
  localparam int CFG_RATE_LSB = 0;
  localparam int CFG_WIDTH_BIT = 8;
  localparam int CFG_STOP_BIT = 9;
  localparam int CFG_PAR_LSB = 10;
  localparam int CFG_FLOW_LSB = 12;
  localparam int RX_PERR_BIT = 8;
  localparam int RX_VALID_BIT = 31;
  localparam int ST_TX_BUSY_BIT = 0;
  localparam int ST_HOLD_FULL_BIT = 1;
  localparam int ST_REMOTE_PAUSED_BIT = 2;
  localparam int ST_PAUSE_SENT_BIT = 3;
  localparam int ST_PERR_BIT = 4;
  localparam int ST_COUNT_LSB = 8;

  // ************************************************************
  // Setting encodings and reset values
  // ************************************************************
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;
  localparam logic [3:0] FLOW_NONE = 4'h0;
  localparam logic [3:0] FLOW_RX = 4'h4;
  localparam logic [3:0] FLOW_TX = 4'h8;
  localparam logic [3:0] FLOW_BOTH = 4'hC;
  localparam int FLOW_RX_BIT = 2;
  localparam int FLOW_TX_BIT = 3;
  localparam logic WIDTH8_RESET = 1'b1;
  localparam logic STOP2_RESET = 1'b0;
  localparam logic [7:0] PAUSE_CHAR = 8'h13;
  localparam logic [7:0] RESUME_CHAR = 8'h11;

  // ************************************************************
  // Receive store and bus answers
  // ************************************************************
  localparam int RX_DEPTH = 16;
  localparam int RX_PTR_W = 4;
  localparam int RX_ENTRY_W = 9;
  localparam logic [4:0] RX_FULL_COUNT = 5'h10;
  localparam logic [4:0] RX_LOW_MARK = 5'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : serial_port_pkg

`default_nettype wire

//--- src/rx_store_mem.sv
/*
  Small receive store: one write port, one read port, registered read data.
  Assumes the caller keeps its own pointers and never reads a word in the
  cycle it is written.
*/
`default_nettype none

module rx_store_mem (
  input wire logic aclk,
  input wire logic wr_en,
  input wire logic [serial_port_pkg::RX_PTR_W-1:0] wr_addr,
  input wire logic [serial_port_pkg::RX_ENTRY_W-1:0] wr_data,
  input wire logic [serial_port_pkg::RX_PTR_W-1:0] rd_addr,
  output logic [serial_port_pkg::RX_ENTRY_W-1:0] rd_data_q
);
  import serial_port_pkg::*;

  logic [RX_ENTRY_W-1:0] store [RX_DEPTH];

  // Write on demand, read every cycle so the head is always on show
  always_ff @(posedge aclk) begin
    if (wr_en) begin
      store[wr_addr] <= wr_data;
    end
    rd_data_q <= store[rd_addr];
  end

endmodule : rx_store_mem

`default_nettype wire

//--- src/serial_port_software_flow_uart.sv
/*
  Three-wire asynchronous serial port with in-band pause/resume pacing and
  an AXI4-Lite register slave. Holds the transmitter, the receiver, the
  pacing logic and the receive store pointers.
  Assumes rxd is asynchronous to aclk, and one AXI4-Lite master.
*/
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`default_nettype none

module serial_port_software_flow_uart #(
  parameter int unsigned CLK_HZ = serial_port_pkg::CLOCK_HZ
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [serial_port_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [serial_port_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rxd,
  output logic txd
);
  import serial_port_pkg::*;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_BITS = 4'b0100, RX_STOP = 4'b1000
  } rx_state_type;

  // ************************************************************
  // Settings and bit divisor
  // ************************************************************
  logic [4:0] line_rate_setting_q;
  logic data_width_setting_q;
  logic stop_bit_setting_q;
  logic [1:0] parity_setting_q;
  logic [3:0] flow_control_setting_q;
  logic [DIV_W-1:0] div_tab [NUM_RATES];
  wire logic [DIV_W-1:0] bit_div = div_tab[line_rate_setting_q];
  wire logic parity_on = parity_setting_q != PAR_NONE;
  wire logic receive_side_pacing = flow_control_setting_q[FLOW_RX_BIT];
  wire logic transmit_side_pacing = flow_control_setting_q[FLOW_TX_BIT];
  wire logic [3:0] body_len = (data_width_setting_q ? 4'h8 : 4'h7) + {3'h0, parity_on};

  // One divisor per supported rate, clock cycles per bit rounded down
  for (genvar i = 0; i < NUM_RATES; i++) begin : g_div
    assign div_tab[i] = DIV_W'(CLK_HZ / RATE_TABLE[i]);
  end

  // ************************************************************
  // AXI4-Lite slave state
  // ************************************************************
  logic aw_have_q, w_have_q, ar_have_q;
  logic [ADDR_W-1:0] aw_addr_q, ar_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  wire logic do_write = aw_have_q && w_have_q && !bvalid;
  wire logic do_read = ar_have_q && !rvalid;
  wire logic wr_cfg = do_write && aw_addr_q == CFG_OFFSET;
  wire logic wr_tx = do_write && aw_addr_q == TXDATA_OFFSET && w_strb_q[0];
  wire logic wr_st = do_write && aw_addr_q == STATUS_OFFSET && w_strb_q[0];
  wire logic wr_hit = aw_addr_q == CFG_OFFSET || aw_addr_q == TXDATA_OFFSET || aw_addr_q == STATUS_OFFSET;
  wire logic rd_hit = ar_addr_q == CFG_OFFSET || ar_addr_q == TXDATA_OFFSET || ar_addr_q == RXDATA_OFFSET ||
    ar_addr_q == STATUS_OFFSET;

  // Field legality: illegal codes leave the setting unchanged
  wire logic [4:0] new_rate = w_data_q[CFG_RATE_LSB +: 5];
  wire logic [1:0] new_par = w_data_q[CFG_PAR_LSB +: 2];
  wire logic [3:0] new_flow = w_data_q[CFG_FLOW_LSB +: 4];
  wire logic rate_ok = new_rate <= RATE_LAST_IDX;
  wire logic par_ok = new_par != 2'h1;
  wire logic flow_ok = new_flow[1:0] == 2'h0;

  // Channel handshakes; each side is held until the answer is free
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      arready <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      ar_have_q <= 1'b0;
      bvalid <= 1'b0;
      rvalid <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        wready <= 1'b0;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
        bvalid <= 1'b1;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (arvalid && arready) begin
        ar_have_q <= 1'b1;
        arready <= 1'b0;
      end
      if (do_read) begin
        ar_have_q <= 1'b0;
        rvalid <= 1'b1;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1; // Reopening late gives the store one cycle to show the new head
      end
    end
  end

  // Address and data capture, no reset needed on payload
  always_ff @(posedge aclk) begin
    if (awvalid && awready) aw_addr_q <= awaddr;
    if (wvalid && wready) begin
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end
    if (arvalid && arready) ar_addr_q <= araddr;
  end

  // ************************************************************
  // Settings register
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_rate_setting_q <= RATE_RESET_IDX;
      data_width_setting_q <= WIDTH8_RESET;
      stop_bit_setting_q <= STOP2_RESET;
      parity_setting_q <= PAR_NONE;
      flow_control_setting_q <= FLOW_NONE;
    end else if (wr_cfg) begin
      if (w_strb_q[0] && rate_ok) line_rate_setting_q <= new_rate;
      if (w_strb_q[1]) begin
        data_width_setting_q <= w_data_q[CFG_WIDTH_BIT];
        stop_bit_setting_q <= w_data_q[CFG_STOP_BIT];
        if (par_ok) parity_setting_q <= new_par;
        if (flow_ok) flow_control_setting_q <= new_flow;
      end
    end
  end

  // ************************************************************
  // Receive store pointers
  // ************************************************************
  logic [RX_PTR_W-1:0] wr_ptr_q, rd_ptr_q;
  logic [4:0] rx_count_q;
  logic rx_avail_q;
  logic [RX_ENTRY_W-1:0] head_q;
  logic [RX_ENTRY_W-1:0] push_data;
  logic push;
  wire logic rx_full = rx_count_q == RX_FULL_COUNT;
  wire logic pop = do_read && ar_addr_q == RXDATA_OFFSET && rx_avail_q;

  rx_store_mem u_store (
    .aclk(aclk),
    .wr_en(push),
    .wr_addr(wr_ptr_q),
    .wr_data(push_data),
    .rd_addr(rd_ptr_q),
    .rd_data_q(head_q)
  );

  // Availability lags the count by a cycle to match the registered head
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      rx_count_q <= '0;
      rx_avail_q <= 1'b0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      rx_count_q <= rx_count_q + {4'h0, push} - {4'h0, pop};
      rx_avail_q <= rx_count_q != 5'h00 && !pop;
    end
  end

  // ************************************************************
  // Receiver
  // ************************************************************
  logic rx_s1_q, rx_s2_q, rx_s3_q, rx_line_q;
  rx_state_type rx_state_q;
  logic [DIV_W-1:0] rx_cnt_q;
  logic [3:0] rx_idx_q;
  logic [8:0] rx_body_q;
  wire logic rx_tick = rx_cnt_q == '0;
  wire logic rx_done = rx_state_q == RX_STOP && rx_tick && rx_line_q;
  wire logic [7:0] rx_char = data_width_setting_q ? rx_body_q[7:0] : {1'b0, rx_body_q[6:0]};
  wire logic rx_pbit = rx_body_q[body_len - 4'h1];
  wire logic rx_perr = parity_on && (rx_pbit != (^rx_char ^ parity_setting_q[0]));
  wire logic rx_is_pause = rx_char == PAUSE_CHAR;
  wire logic rx_is_resume = rx_char == RESUME_CHAR;
  wire logic rx_consume = flow_control_setting_q != FLOW_NONE && (rx_is_pause || rx_is_resume);
  assign push = rx_done && !rx_consume && !rx_full;
  assign push_data = {rx_perr, rx_char};

  // Three-stage sampler; only agreeing later stages move the line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
      rx_line_q <= 1'b1;
    end else begin
      rx_s1_q <= rxd;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      if (rx_s2_q == rx_s3_q) rx_line_q <= rx_s3_q;
    end
  end

  // Start edge, half-bit wait to centre, then one sample per bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q <= '0;
      rx_idx_q <= '0;
      rx_body_q <= '0;
    end else begin
      if (!rx_tick) rx_cnt_q <= rx_cnt_q - 1'b1;
      unique case (rx_state_q)
        RX_IDLE: begin
          if (!rx_line_q) begin
            rx_state_q <= RX_START;
            rx_cnt_q <= bit_div >> 1;
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_state_q <= rx_line_q ? RX_IDLE : RX_BITS; // Glitch shorter than half a bit
            rx_cnt_q <= bit_div - 1'b1;
            rx_idx_q <= '0;
          end
        end
        RX_BITS: begin
          if (rx_tick) begin
            rx_body_q[rx_idx_q] <= rx_line_q;
            rx_idx_q <= rx_idx_q + 1'b1;
            rx_cnt_q <= bit_div - 1'b1;
            if (rx_idx_q == body_len - 4'h1) rx_state_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_tick) rx_state_q <= RX_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Pacing state and parity error flag
  // ************************************************************
  logic remote_paused_q, pause_sent_q, perr_flag_q;
  logic tx_hold_full_q;
  logic [7:0] tx_hold_q;
  logic [3:0] tx_left_q;
  wire logic tx_idle = tx_left_q == 4'h0;
  wire logic need_pause = receive_side_pacing && rx_full && !pause_sent_q;
  wire logic need_resume = pause_sent_q && (rx_count_q <= RX_LOW_MARK || !receive_side_pacing);
  wire logic send_ctl = tx_idle && (need_pause || need_resume);
  wire logic data_gate = !(transmit_side_pacing && remote_paused_q);
  wire logic send_data = tx_idle && !send_ctl && tx_hold_full_q && data_gate;
  wire logic [7:0] tx_char = send_ctl ? (need_pause ? PAUSE_CHAR : RESUME_CHAR) : tx_hold_q;

  // Control characters jump the queue; a resume clears the sent mark
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_paused_q <= 1'b0;
      pause_sent_q <= 1'b0;
      perr_flag_q <= 1'b0;
    end else begin
      if (!transmit_side_pacing) remote_paused_q <= 1'b0;
      else if (rx_done && rx_is_pause) remote_paused_q <= 1'b1;
      else if (rx_done && rx_is_resume) remote_paused_q <= 1'b0;
      if (send_ctl) pause_sent_q <= need_pause;
      if (rx_done && rx_perr) perr_flag_q <= 1'b1;
      else if (wr_st && w_data_q[ST_PERR_BIT]) perr_flag_q <= 1'b0;
    end
  end

  // ************************************************************
  // Transmitter
  // ************************************************************
  logic [11:0] tx_frame_q;
  logic [DIV_W-1:0] tx_cnt_q;
  wire logic tx_par = (data_width_setting_q ? ^tx_char : ^tx_char[6:0]) ^ parity_setting_q[0];
  wire logic [3:0] tx_len = body_len + 4'h2 + {3'h0, stop_bit_setting_q};
  logic [11:0] tx_frame;

  // Start bit, data LSB first, parity when on, then idle ones
  always_comb begin
    tx_frame = '1;
    tx_frame[0] = 1'b0;
    tx_frame[7:1] = tx_char[6:0];
    if (data_width_setting_q) tx_frame[8] = tx_char[7];
    if (parity_on) tx_frame[body_len] = tx_par;
  end

  // Frame shifter; extra stop bit is just one more idle bit period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_frame_q <= '1;
      tx_left_q <= '0;
      tx_cnt_q <= '0;
      txd <= 1'b1;
      tx_hold_full_q <= 1'b0;
      tx_hold_q <= '0;
    end else begin
      if (send_ctl || send_data) begin
        tx_frame_q <= tx_frame;
        tx_left_q <= tx_len;
        tx_cnt_q <= bit_div - 1'b1;
        txd <= 1'b0;
      end else if (!tx_idle) begin
        if (tx_cnt_q == '0) begin
          tx_frame_q <= {1'b1, tx_frame_q[11:1]};
          tx_left_q <= tx_left_q - 1'b1;
          tx_cnt_q <= bit_div - 1'b1;
          txd <= tx_left_q > 4'h1 ? tx_frame_q[1] : 1'b1;
        end else begin
          tx_cnt_q <= tx_cnt_q - 1'b1;
        end
      end
      if (send_data) tx_hold_full_q <= 1'b0;
      else if (wr_tx && !tx_hold_full_q) begin
        tx_hold_full_q <= 1'b1;
        tx_hold_q <= w_data_q[7:0];
      end
    end
  end

  // ************************************************************
  // Read data and responses
  // ************************************************************
  wire logic [31:0] cfg_word = {16'h0000, flow_control_setting_q, parity_setting_q, stop_bit_setting_q,
    data_width_setting_q, 3'h0, line_rate_setting_q};
  wire logic [31:0] st_word = {19'h0_0000, rx_count_q, 3'h0, perr_flag_q, pause_sent_q, remote_paused_q,
    tx_hold_full_q, !tx_idle};
  wire logic [31:0] rx_word = rx_avail_q ? {1'b1, 22'h00_0000, head_q} : 32'h0000_0000;
  wire logic [31:0] rd_mux = ar_addr_q == CFG_OFFSET ? cfg_word :
    ar_addr_q == RXDATA_OFFSET ? rx_word : ar_addr_q == STATUS_OFFSET ? st_word : 32'h0000_0000;

  // Answers are registered with the valid that marks them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata <= '0;
      rresp <= RESP_OKAY;
      bresp <= RESP_OKAY;
    end else begin
      if (do_read) begin
        rdata <= rd_mux;
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (do_write) bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ctl_load(logic [7:0] c);
    send_ctl && tx_char == c ##1 !tx_idle && tx_frame_q[7:1] == c[6:0] &&
      (tx_frame_q[8] == c[7] || !data_width_setting_q);
  endsequence

  property p_reset_settings;
    $rose(aresetn) |-> line_rate_setting_q == RATE_RESET_IDX && data_width_setting_q && !stop_bit_setting_q;
  endproperty
  a_reset_settings: assert property (p_reset_settings) else $error("bad settings after reset");

  property p_reset_flow;
    $rose(aresetn) |-> flow_control_setting_q == FLOW_NONE && parity_setting_q == PAR_NONE;
  endproperty
  a_reset_flow: assert property (p_reset_flow) else $error("pacing or parity active after reset");

  property p_legal_codes;
    parity_setting_q != 2'h1 && flow_control_setting_q[1:0] == 2'h0 && line_rate_setting_q <= RATE_LAST_IDX;
  endproperty
  a_legal_codes: assert property (p_legal_codes) else $error("illegal setting code held");

  property p_frame_len;
    send_data |=> tx_left_q == 4'hA + {3'h0, $past(stop_bit_setting_q)} + {3'h0, $past(parity_on)} -
      {3'h0, !$past(data_width_setting_q)};
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");

  property p_tx_parity;
    send_data && parity_on && data_width_setting_q |=>
      tx_frame_q[9] == (^tx_frame_q[8:1] ^ $past(parity_setting_q[0]));
  endproperty
  a_tx_parity: assert property (p_tx_parity) else $error("transmit parity wrong");

  property p_pause_sent;
    tx_idle && receive_side_pacing && rx_full && !pause_sent_q |-> s_ctl_load(PAUSE_CHAR) ##0 pause_sent_q;
  endproperty
  a_pause_sent: assert property (p_pause_sent) else $error("pause not sent on full store");

  property p_resume_sent;
    tx_idle && pause_sent_q && rx_count_q <= RX_LOW_MARK && !need_pause |-> s_ctl_load(RESUME_CHAR);
  endproperty
  a_resume_sent: assert property (p_resume_sent) else $error("resume not sent");

  property p_hold_while_paused;
    transmit_side_pacing && remote_paused_q |-> !send_data;
  endproperty
  a_hold_while_paused: assert property (p_hold_while_paused) else $error("data sent while paused");

  property p_resume_clears;
    transmit_side_pacing && rx_done && rx_is_resume |=> !remote_paused_q;
  endproperty
  a_resume_clears: assert property (p_resume_clears) else $error("resume did not release");

  property p_filtered;
    rx_done && flow_control_setting_q != FLOW_NONE && (rx_is_pause || rx_is_resume) |=>
      $stable(wr_ptr_q) || $past(pop);
  endproperty
  a_filtered: assert property (p_filtered) else $error("pacing character stored");

  property p_centre_wait;
    rx_state_q == RX_IDLE && !rx_line_q |=> rx_state_q == RX_START && rx_cnt_q == $past(bit_div) >> 1;
  endproperty
  a_centre_wait: assert property (p_centre_wait) else $error("start not centred");

  property p_perr_flag;
    rx_done && rx_perr |=> perr_flag_q [*2];
  endproperty
  a_perr_flag: assert property (p_perr_flag) else $error("parity error flag not raised");

endmodule : serial_port_software_flow_uart

`default_nettype wire

//--- test/remote_serial_peer.sv
/*
  Remote serial peer: sends frames on rxd and decodes frames seen on txd.
  Assumes the bench sets div and nb to match the port settings.
*/
`default_nettype none
module remote_serial_peer (
  input wire logic aclk,
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  int div = 21;
  int nb = 8;
  int got[$];
  int v;
  // ********************
  // Sender and decoder
  // ********************
  initial rxd = 1'b1;
  // One start, n body bits LSB first, one stop; pause or resume are bodies too
  task automatic send(input int body, input int n);
    rxd <= 1'b0;
    repeat (div) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      rxd <= body[i];
      repeat (div) @(posedge aclk);
    end
    rxd <= 1'b1;
    repeat (div) @(posedge aclk);
  endtask : send
  // Sample bit centres after the falling start edge, parity kept in the body
  initial forever begin
    @(negedge txd);
    repeat (div / 2) @(posedge aclk);
    v = 0;
    for (int i = 0; i < nb; i++) begin
      repeat (div) @(posedge aclk);
      v[i] = txd;
    end
    got.push_back(v);
  end
endmodule : remote_serial_peer
`default_nettype wire

//--- test/tb_serial_port_software_flow_uart.sv
/*
  Self-checking bench for the serial port: AXI4-Lite master tasks, a remote
  peer on the link, expected frames worked out from the settings.
  Assumes CLK_HZ lowered to 2.5 MHz so divisors stay short.
*/
`default_nettype none
module tb_serial_port_software_flow_uart;
  import serial_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awready, wready, bvalid, arready, rvalid, txd, rxd;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, d;
  int n_mismatch = 0, comparisons = 0, cyc = 0, body, par, w;
  integer seed = 32'h9d265b47;
  int q[$];
  serial_port_software_flow_uart #(.CLK_HZ(2_500_000)) u_serial_port_software_flow_uart (.aclk, .aresetn,
    .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .rxd, .txd);
  remote_serial_peer u_remote_serial_peer (.aclk, .txd, .rxd);
  // ********************
  // Clock, timeout, helpers
  // ********************
  always #2.5 aclk = ~aclk;
  // Hang guard, well above the expected run length
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wrap_up();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  // Each channel released at the edge its ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    awaddr <= a;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
      if (bvalid && bready) begin
        bready <= 1'b0;
        rs = bresp;
      end
    end while (bready);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready && arvalid) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rready <= 1'b0;
        dt = rdata;
        r = rresp;
      end
    end while (rready);
  endtask : rd
  // Expected line body: data bits, then parity when enabled
  function automatic int frame(input int ch, input int wd, input int p);
    int dd = ch & ((1 << wd) - 1);
    return (p == 0) ? dd : dd | (int'(^dd ^ (p == 3)) << wd);
  endfunction : frame
  task automatic wait_tx();
    while (u_remote_serial_peer.got.size() == 0) @(posedge aclk);
  endtask : wait_tx
  // ********************
  // Scenarios
  // ********************
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(CFG_OFFSET, d, rs);
    chk("cfg reset", d, 32'h0000_0102);
    rd(8'h10, d, rs);
    chk("unmapped resp", {30'h0, rs}, {30'h0, RESP_SLVERR});
    chk("unmapped rdata", d, 32'h0000_0000);
    wr(8'h10, 32'h0000_0000);
    chk("unmapped bresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
    // Every parity code and both widths, with one corrupted parity bit
    for (int k = 0; k < 6; k++) begin
      par = (k % 3 == 0) ? 0 : k % 3 + 1;
      w = (k < 3) ? 8 : 7;
      wr(CFG_OFFSET, 32'h0000_0002 | (w == 8) << 8 | (k & 1) << 9 | par << 10);
      body = $random(seed) & 8'hFF;
      u_remote_serial_peer.nb = w + (par != 0);
      wr(TXDATA_OFFSET, body);
      wait_tx();
      chk("tx frame", u_remote_serial_peer.got.pop_front(), frame(body, w, par));
      repeat (60) @(posedge aclk);
      u_remote_serial_peer.send(frame(body, w, par) ^ (k == 4) << w, w + (par != 0));
      rd(RXDATA_OFFSET, d, rs);
      chk("rx char", d, 32'h8000_0000 | (k == 4) << 8 | (body & ((1 << w) - 1)));
    end
    // Sticky parity error from the corrupted character, then cleared by a write of one
    rd(STATUS_OFFSET, d, rs);
    chk("perr sticky", d, 32'h0000_0010);
    wr(STATUS_OFFSET, 32'h0000_0010);
    chk("status bresp", {30'h0, rs}, {30'h0, RESP_OKAY});
    rd(STATUS_OFFSET, d, rs);
    chk("perr cleared", d, 32'h0000_0000);
    // Fastest rate, transmit pacing holds and releases output
    u_remote_serial_peer.div = 10;
    u_remote_serial_peer.nb = 8;
    wr(CFG_OFFSET, 32'h0000_8100);
    u_remote_serial_peer.send(PAUSE_CHAR, 8);
    wr(TXDATA_OFFSET, 32'h0000_0055);
    repeat (300) @(posedge aclk);
    chk("paused", u_remote_serial_peer.got.size(), 0);
    rd(STATUS_OFFSET, d, rs);
    chk("paused status", d, 32'h0000_0006);
    u_remote_serial_peer.send(RESUME_CHAR, 8);
    wait_tx();
    chk("resumed", u_remote_serial_peer.got.pop_front(), 32'h0000_0055);
    rd(RXDATA_OFFSET, d, rs);
    chk("filtered", d, 32'h0000_0000);
    // Combined pacing: fill the store, then drain below the low mark
    wr(CFG_OFFSET, 32'h0000_C100);
    for (int i = 0; i < 16; i++) begin
      q.push_back(32'h20 + i);
      u_remote_serial_peer.send(32'h20 + i, 8);
    end
    wait_tx();
    chk("pause sent", u_remote_serial_peer.got.pop_front(), PAUSE_CHAR);
    for (int i = 0; i < 9; i++) begin
      rd(RXDATA_OFFSET, d, rs);
      chk("drain", d, 32'h8000_0000 | q.pop_front());
    end
    wait_tx();
    chk("resume sent", u_remote_serial_peer.got.pop_front(), RESUME_CHAR);
    wrap_up();
  end
endmodule : tb_serial_port_software_flow_uart
`default_nettype wire
